// ===== dv/wmc_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module wmc_core_tb_top
  import wmc_pkg::*;
;
  localparam logic [2:0] MY_ID = 3'h2;  // id of the device under test
  logic        CLK, RST_N, line, host_tx, rx_stb, POS_CLEAR, REVERSED, DATA_OUT, DATA_OE;
  logic [7:0]  rx_byte, RAMP_RATE, REPLY_DELAY;
  logic [15:0] POSITION, SPEED, DRIVE, SET_POINT, END_POINT, MAX_SPEED, spd;
  logic [15:0] exp_q[$];  // expected reply bytes, oldest first
  int          n_mismatch = 0, samples_checked = 0, n_clr = 0, gap, dv;
  // device drives only while enabled, host idles high otherwise
  assign line = DATA_OE ? DATA_OUT : host_tx;
  wmc_core #(.HALF_SEC_CYCLES(200)) u_wmc_core (.CLK(CLK), .RST_N(RST_N), .DATA_IN(line),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .DEV_ID(MY_ID), .POSITION(POSITION),
    .SPEED(SPEED), .POS_CLEAR(POS_CLEAR), .REVERSED(REVERSED), .DRIVE(DRIVE),
    .SET_POINT(SET_POINT), .END_POINT(END_POINT), .MAX_SPEED(MAX_SPEED),
    .RAMP_RATE(RAMP_RATE), .REPLY_DELAY(REPLY_DELAY));
  wmc_host_model u_wmc_host_model (.clk(CLK), .line(line), .tx(host_tx), .rx_stb(rx_stb),
    .rx_byte(rx_byte));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // command byte: number above, id in the low three bits
  task automatic cmd(input logic [4:0] c, input logic [2:0] id);
    u_wmc_host_model.send({c, id});
  endtask : cmd
  // bounded wait for the line enable to reach a level
  task automatic wait_oe(input logic lvl, output int n);
    n = 0;
    while (DATA_OE !== lvl && n < 8000) begin
      @(negedge CLK);
      n++;
    end
  endtask : wait_oe
  // reply watcher and clear-pulse counter
  always @(posedge CLK) begin
    if (rx_stb === 1'b1) check("reply", exp_q.pop_front(), {8'h00, rx_byte});
    if (POS_CLEAR === 1'b1) n_clr++;
  end
  initial begin
    repeat (103000) @(posedge CLK);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    RST_N = 1'b0;
    SPEED = 16'h0000;
    void'($urandom(32'h8493));
    POSITION = 16'($urandom);
    repeat (10) @(negedge CLK);
    RST_N = 1'b1;
    check("max speed", 16'h0024, MAX_SPEED);
    check("ramp", 16'h000F, {8'h00, RAMP_RATE});
    check("delay", 16'h0073, {8'h00, REPLY_DELAY});
    check("reversed", 16'h0000, {15'h0, REVERSED});
    cmd(reverse_direction_cmd, MY_ID);
    check("reversed", 16'h0001, {15'h0, REVERSED});
    // wheel at rest, set point zero: drive is the position error times four
    dv = -4 * int'($signed(POSITION));
    check("drive", dv > 32767 ? 16'h7FFF : dv < -32768 ? 16'h8000 : 16'(dv), DRIVE);
    cmd(reverse_direction_cmd, 3'h0);
    check("reversed", 16'h0001, {15'h0, REVERSED});
    // ramp changed while the wheel stands
    cmd(ramp_rate_cmd, MY_ID);
    u_wmc_host_model.send(8'h00);
    check("ramp", 16'h0001, {8'h00, RAMP_RATE});
    spd = 16'($urandom);
    cmd(max_speed_cmd, 3'h0);
    u_wmc_host_model.send(spd[15:8]);
    u_wmc_host_model.send(spd[7:0]);
    check("max speed", spd, MAX_SPEED);
    // other id, arguments that would read as a delay command for us
    cmd(max_speed_cmd, 3'h3);
    u_wmc_host_model.send({reply_delay_cmd, MY_ID});
    u_wmc_host_model.send(8'h05);
    check("max speed", spd, MAX_SPEED);
    check("delay", 16'h0073, {8'h00, REPLY_DELAY});
    // broadcast query must be ignored, else the delay command below is lost
    cmd(POS_QUERY_CMD, 3'h0);
    cmd(reply_delay_cmd, MY_ID);
    u_wmc_host_model.send(8'h00);
    check("delay", 16'h0000, {8'h00, REPLY_DELAY});
    // speed query, value changed after the command lands
    SPEED = 16'($urandom);
    exp_q.push_back({8'h00, SPEED[15:8]});
    exp_q.push_back({8'h00, SPEED[7:0]});
    cmd(speed_query_cmd, MY_ID);
    SPEED = ~SPEED;
    wait_oe(1'b1, gap);
    wait_oe(1'b0, gap);
    wait_oe(1'b1, gap);
    check("byte gap", 16'h0001, {15'h0, gap >= BASE_CYC && gap < 8000});
    wait_oe(1'b0, gap);
    repeat (BIT_CYC) @(negedge CLK);
    check("line enable", 16'h0000, {15'h0, DATA_OE});
    repeat (3) cmd(clear_position_cmd, 3'h0);
    check("clear pulses", 16'h0003, 16'(n_clr));
    check("set point", 16'h0000, SET_POINT);
    check("end point", 16'h0000, END_POINT);
    check("max speed", spd, MAX_SPEED);
    check("ramp", 16'h0001, {8'h00, RAMP_RATE});
    check("reversed", 16'h0001, {15'h0, REVERSED});
    check("replies left", 16'h0000, 16'(exp_q.size()));
    tally_and_finish;
  end
endmodule : wmc_core_tb_top
`default_nettype wire

// ===== dv/wmc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host end of the shared serial line
module wmc_host_model
  import wmc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       line,
  output var  logic       tx,
  output var  logic       rx_stb,
  output var  logic [7:0] rx_byte
);
  logic busy;  // own frame in flight, receiver deaf
  initial begin
    tx = 1'b1;
    busy = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end
  // one frame: start, eight bits lsb first, stop, changed at falling edge
  task automatic send(input logic [7:0] b);
    busy = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      tx = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT_CYC - 1) @(negedge clk);
    end
    busy = 1'b0;
  endtask : send
  // reply receiver, samples mid bit, one-cycle strobe per byte
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge line);
      if (!busy) begin
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge clk);
          b[i] = line;
        end
        repeat (BIT_CYC) @(posedge clk);
        rx_byte <= b;
        rx_stb <= 1'b1;
        @(posedge clk);
        rx_stb <= 1'b0;
      end
    end
  end
endmodule : wmc_host_model
`default_nettype wire

// ===== rtl/wmc_core.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - command number shifted three, id low bits
// - id zero broadcasts, never for queries
// - clear zeroes position, end and set point
// - triple clear resyncs, configuration kept
// - reverse command flips positive direction immediately
// - repeated reverse keeps reversed until power-down
// - delay command byte sets reply wait
// - wait is delay times 4.34us plus 40us
// - delay value is 115 after power-up
// - query value captured at command, sent later
// - max speed sixteen bits, high byte first
// - max speed 36 after power-up
// - raised limit ramps, lowered limit clips instantly
// - drive regulated both ways to track speed
// - set point steps every half second
// - ramp command one byte, default 15
// - ramp zero stored as one
// - accelerate to limit or brake for end
// - 19.2k, eight bits lsb first, one stop
// - line released except while sending reply
// - argument bytes always consumed, even unaddressed
// - up to seven devices, told by id
module wmc_core
  import wmc_pkg::*;
#(
  parameter int HALF_SEC_CYCLES = HALF_CYC,  // motion update period
  parameter int DRIVE_SHIFT     = 2          // position error gain
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        DATA_IN,
  output var  logic        DATA_OUT,
  output var  logic        DATA_OE,
  input  wire logic [2:0]  DEV_ID,
  input  wire logic [15:0] POSITION,
  input  wire logic [15:0] SPEED,
  output var  logic        POS_CLEAR,
  output var  logic        REVERSED,
  output var  logic [15:0] DRIVE,
  output var  logic [15:0] SET_POINT,
  output var  logic [15:0] END_POINT,
  output var  logic [15:0] MAX_SPEED,
  output var  logic [7:0]  RAMP_RATE,
  output var  logic [7:0]  REPLY_DELAY
);
  localparam int HS_W = $clog2(HALF_SEC_CYCLES);
  if (HALF_SEC_CYCLES < 2 || DRIVE_SHIFT < 0 || DRIVE_SHIFT > 3) begin : g_chk
    $error("unsupported parameter value");
  end

  // ****************************************
  // line driver
  // ****************************************
  wmc_serial_if ser ();

  wmc_uart #(
    .BIT_CYCLES (BIT_CYC)
  ) u_uart (
    .clk      (CLK),
    .rst_n    (RST_N),
    .data_in  (DATA_IN),
    .data_out (DATA_OUT),
    .data_oe  (DATA_OE),
    .ser      (ser)
  );

  // ****************************************
  // command decode
  // ****************************************
  wmc_state_type state;        // sequencer state
  wmc_state_type next_state;   // sequencer next state
  logic [4:0]    cmd_q;        // command awaiting arguments
  logic          hit_q;        // that command addresses us
  logic [7:0]    arg_hi;       // first of two argument bytes
  logic [15:0]   rep_val;      // captured reply, msb byte first
  logic [1:0]    rep_left;     // reply bytes still to send
  logic [15:0]   wait_cyc;     // reply wait cycle divider
  logic [7:0]    ticks_left;   // delay ticks still to wait
  logic [15:0]   wait_seen;    // cycles waited, checked below
  logic [HS_W-1:0] hs_cnt;     // half second divider
  logic          hs_tick;      // half second enable pulse
  logic [16:0]   vel;          // signed step per half second

  wire [4:0]  rx_cmd   = ser.rx_byte[7:CMD_LSB];
  wire [2:0]  rx_id    = ser.rx_byte[CMD_LSB-1:0];
  wire        is_query = rx_cmd == POS_QUERY_CMD || rx_cmd == speed_query_cmd
                      || rx_cmd == ARRIVE_QUERY_CMD;
  // id zero never matches as an own id, so a zero device answers no query
  wire        hit      = rx_id == ALL_ID ? !is_query : rx_id == DEV_ID;
  wire        two_args = rx_cmd == travel_positions_cmd || rx_cmd == max_speed_cmd;
  wire        one_arg  = rx_cmd == ARRIVE_QUERY_CMD || rx_cmd == reply_delay_cmd
                      || rx_cmd == ramp_rate_cmd;
  wire        idle_rx  = state == ST_IDLE && ser.rx_valid;
  wire        arg_rx   = state == ST_ARG2 && ser.rx_valid;
  wire        arg_done = arg_rx && hit_q;
  wire [15:0] arg_word = {arg_hi, ser.rx_byte};
  wire        do_clear = idle_rx && hit && rx_cmd == clear_position_cmd;
  wire        do_rev   = idle_rx && hit && rx_cmd == reverse_direction_cmd;
  wire        do_query = idle_rx && hit && is_query && !one_arg;
  wire        do_travel_positions_cmd  = arg_done && cmd_q == travel_positions_cmd;
  wire        do_delay = arg_done && cmd_q == reply_delay_cmd;
  wire        do_max   = arg_done && cmd_q == max_speed_cmd;
  wire        do_ramp  = arg_done && cmd_q == ramp_rate_cmd;
  wire        do_arriv = arg_done && cmd_q == ARRIVE_QUERY_CMD;

  // arrival: stopped and within tolerance of the end point
  wire [15:0] pos_err  = POSITION - END_POINT;
  wire [15:0] pos_mag  = pos_err[15] ? 16'(-pos_err) : pos_err;
  wire        arrived  = SPEED == 16'h0000 && pos_mag <= {8'h00, ser.rx_byte};

  // ****************************************
  // sequencer next state
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (ser.rx_valid) begin
          if (two_args)      next_state = ST_ARG1;
          else if (one_arg)  next_state = ST_ARG2;
          else if (do_query) next_state = ST_WAIT;
        end
      end
      ST_ARG1: begin
        if (ser.rx_valid) next_state = ST_ARG2;
      end
      ST_ARG2: begin
        if (ser.rx_valid) next_state = do_arriv ? ST_WAIT : ST_IDLE;
      end
      ST_WAIT: begin
        if (ser.tx_ready && wait_cyc == 16'h0000 && ticks_left == 8'h00) begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        next_state = rep_left == 2'h1 ? ST_IDLE : ST_WAIT;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  wire enter_wait = next_state == ST_WAIT && state != ST_WAIT;
  assign ser.tx_valid = state == ST_SEND;
  assign ser.tx_byte  = rep_val[15:8];

  // state register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) state <= ST_IDLE;
    else        state <= next_state;
  end

  // ****************************************
  // command capture and reply data
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_q    <= 5'h00;
      hit_q    <= 1'b0;
      arg_hi   <= 8'h00;
      rep_val  <= 16'h0000;
      rep_left <= 2'h0;
    end else begin
      if (idle_rx) begin
        cmd_q <= rx_cmd;
        hit_q <= hit;
      end
      if (state == ST_ARG1 && ser.rx_valid) arg_hi <= ser.rx_byte;
      // value frozen now, only its sending waits
      if (do_query) begin
        rep_val  <= rx_cmd == POS_QUERY_CMD ? POSITION : SPEED;
        rep_left <= 2'h2;
      end else if (do_arriv) begin
        rep_val  <= {arrived ? 8'hFF : 8'h00, 8'h00};
        rep_left <= 2'h1;
      end else if (state == ST_SEND) begin
        rep_val  <= {rep_val[7:0], 8'h00};
        rep_left <= rep_left - 2'h1;
      end
    end
  end

  // ****************************************
  // reply wait: fixed part then delay ticks
  // ****************************************
  // the fixed part also covers half a bit, since a byte is taken mid stop bit
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wait_cyc   <= 16'h0000;
      ticks_left <= 8'h00;
    end else if (enter_wait) begin
      wait_cyc   <= 16'(BASE_CYC + BIT_CYC / 2 - 1);
      ticks_left <= REPLY_DELAY;
    end else if (state == ST_WAIT && ser.tx_ready) begin
      if (wait_cyc != 16'h0000) begin
        wait_cyc <= wait_cyc - 16'h0001;
      end else if (ticks_left != 8'h00) begin
        ticks_left <= ticks_left - 8'h01;
        wait_cyc   <= 16'(TICK_CYC - 1);
      end
    end
  end

  // ****************************************
  // configuration, untouched by clear
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REVERSED    <= 1'b0;
      REPLY_DELAY <= DELAY_RST;
      MAX_SPEED   <= MAXSPD_RST;
      RAMP_RATE   <= RAMP_RST;
    end else begin
      if (do_rev)   REVERSED    <= 1'b1;
      if (do_delay) REPLY_DELAY <= ser.rx_byte;
      if (do_max)   MAX_SPEED   <= arg_word;
      if (do_ramp) begin
        RAMP_RATE <= ser.rx_byte == 8'h00 ? RAMP_MIN : ser.rx_byte;
      end
    end
  end

  // ****************************************
  // motion profile, one step per half second
  // ****************************************
  wire [15:0] remain   = END_POINT - SET_POINT;
  wire [15:0] rem_mag  = remain[15] ? 16'(-remain) : remain;
  wire [16:0] vel_abs  = vel[16] ? 17'(-vel) : vel;
  wire [15:0] vmag     = vel_abs[15:0];
  wire        toward   = remain != 16'h0000 && (vmag == 16'h0000 || vel[16] == remain[15]);
  wire [31:0] stop_lhs = 32'(vmag) * 32'(vmag);
  wire [31:0] stop_rhs = 32'({RAMP_RATE, 1'b0}) * 32'(rem_mag);
  wire        brake    = !toward || stop_lhs >= stop_rhs;
  // a limit written in the step cycle already bounds that step
  wire [15:0] spd_lim  = do_max ? arg_word : MAX_SPEED;
  wire [16:0] acc_sum  = {1'b0, vmag} + {9'h000, RAMP_RATE};
  wire [15:0] acc_mag  = acc_sum > {1'b0, spd_lim} ? spd_lim : acc_sum[15:0];
  wire [15:0] dec_raw  = vmag > {8'h00, RAMP_RATE} ? vmag - {8'h00, RAMP_RATE} : 16'h0000;
  wire [15:0] dec_mag  = dec_raw > spd_lim ? spd_lim : dec_raw;
  wire [15:0] new_mag  = brake ? dec_mag : acc_mag;
  wire        new_neg  = brake ? vel[16] : remain[15];
  wire [15:0] step_mag = !brake && new_mag > rem_mag ? rem_mag : new_mag;
  wire [16:0] next_vel = new_neg ? 17'(-{1'b0, step_mag}) : {1'b0, step_mag};
  wire [16:0] clip_vel = vel[16] ? 17'(-{1'b0, arg_word}) : {1'b0, arg_word};

  // half second enable
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hs_cnt  <= '0;
      hs_tick <= 1'b0;
    end else begin
      hs_tick <= hs_cnt == HS_W'(HALF_SEC_CYCLES - 1);
      hs_cnt  <= hs_cnt == HS_W'(HALF_SEC_CYCLES - 1) ? '0 : hs_cnt + HS_W'(1);
    end
  end

  // end point, set point and speed
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      END_POINT <= 16'h0000;
      SET_POINT <= 16'h0000;
      vel       <= 17'h0_0000;
      POS_CLEAR <= 1'b0;
    end else begin
      POS_CLEAR <= do_clear;
      if (do_clear) begin
        END_POINT <= 16'h0000;
        SET_POINT <= 16'h0000;
        vel       <= 17'h0_0000;
      end else begin
        if (do_travel_positions_cmd) END_POINT <= END_POINT + arg_word;
        if (do_max && vmag > arg_word) begin
          vel <= clip_vel;
        end else if (hs_tick) begin
          vel       <= next_vel;
          SET_POINT <= SET_POINT + next_vel[15:0];
        end
      end
    end
  end

  // ****************************************
  // drive regulation, push or hold back
  // ****************************************
  wire [19:0] err_ext = {{4{SET_POINT[15]}}, SET_POINT}
                      - {{4{POSITION[15]}}, POSITION};
  wire [19:0] drv_sum = (err_ext << DRIVE_SHIFT) + {{3{vel[16]}}, vel}
                      - {{4{SPEED[15]}}, SPEED};
  wire        drv_ok  = drv_sum[19:15] == 5'h00 || drv_sum[19:15] == 5'h1F;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) DRIVE <= 16'h0000;
    else        DRIVE <= drv_ok ? drv_sum[15:0] : (drv_sum[19] ? 16'h8000 : 16'h7FFF);
  end

  // ****************************************
  // checks
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)                    wait_seen <= 16'h0000;
    else if (enter_wait)           wait_seen <= 16'h0001;
    else if (state == ST_WAIT && ser.tx_ready) wait_seen <= wait_seen + 16'h0001;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  clear_zeroes_a: assert property (do_clear |=> SET_POINT == 16'h0000
    && END_POINT == 16'h0000 && vel == 17'h0_0000 && POS_CLEAR)
    else $error("clear did not zero the motion state");
  reverse_set_a: assert property (do_rev |=> REVERSED)
    else $error("reverse not applied");
  reverse_hold_a: assert property (REVERSED |=> REVERSED)
    else $error("reverse setting fell back");
  reply_wait_a: assert property (state == ST_SEND
    |-> int'(wait_seen) >= BASE_CYC + int'(REPLY_DELAY) * TICK_CYC)
    else $error("reply sent too early");
  power_up_a: assert property (disable iff (1'b0)
    !$past(RST_N) && RST_N |-> REPLY_DELAY == DELAY_RST
    && MAX_SPEED == MAXSPD_RST && RAMP_RATE == RAMP_RST)
    else $error("wrong power-up configuration");
  ramp_floor_a: assert property (do_ramp && ser.rx_byte == 8'h00
    |=> RAMP_RATE == RAMP_MIN)
    else $error("zero ramp stored");
  speed_clip_a: assert property ((do_max || hs_tick) |=> vmag <= MAX_SPEED)
    else $error("speed above limit");
  arg_skip_a: assert property (idle_rx && two_args && !hit
    |=> state == ST_ARG1 ##0 $stable(MAX_SPEED))
    else $error("arguments not consumed");
  query_capture_a: assert property (do_query && rx_cmd == speed_query_cmd
    |=> rep_val == $past(SPEED))
    else $error("query value not captured");
  broadcast_query_a: assert property (idle_rx && is_query && rx_id == ALL_ID
    && rx_cmd != ARRIVE_QUERY_CMD |=> state == ST_IDLE)
    else $error("broadcast query answered");

  cover property (state == ST_SEND && rep_left == 2'h1);
  cover property (do_clear ##1 do_clear);
  cover property (hs_tick && vel != 17'h0_0000 && brake);
endmodule : wmc_core
`default_nettype wire

// ===== rtl/wmc_pkg.sv
`default_nettype none
package wmc_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int  CLK_HZ     = 10_000_000;            // system clock rate
  localparam int  CLK_NS     = 100;                   // clock period
  localparam int  BAUD       = 19_200;                // serial bit rate
  localparam int  BIT_CYC    = (CLK_HZ + BAUD / 2) / BAUD; // cycles per bit
  localparam real TICK_US    = 4.34;                  // reply delay unit
  localparam int  TICK_CYC   = int'($ceil(TICK_US * 1000.0 / CLK_NS));
  localparam int  BASE_US    = 40;                    // fixed reply wait
  localparam int  BASE_CYC   = (BASE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int  HALF_MS    = 500;                   // motion update period
  localparam int  HALF_CYC   = HALF_MS * (CLK_HZ / 1000);
  // ****************************************
  // command byte layout
  // ****************************************
  localparam int         CMD_LSB          = 3;        // command number position
  localparam logic [2:0] ALL_ID           = 3'h0;     // broadcast identifier
  localparam logic [4:0] POS_QUERY_CMD    = 5'h01;
  localparam logic [4:0] speed_query_cmd  = 5'h02;
  localparam logic [4:0] ARRIVE_QUERY_CMD = 5'h03;
  localparam logic [4:0] travel_positions_cmd = 5'h04;
  localparam logic [4:0] clear_position_cmd   = 5'h05;
  localparam logic [4:0] reverse_direction_cmd = 5'h06;
  localparam logic [4:0] reply_delay_cmd  = 5'h07;
  localparam logic [4:0] max_speed_cmd    = 5'h08;
  localparam logic [4:0] ramp_rate_cmd    = 5'h09;
  // ****************************************
  // power-up values
  // ****************************************
  localparam logic [7:0]  DELAY_RST  = 8'h73;         // reply delay 115
  localparam logic [15:0] MAXSPD_RST = 16'h0024;      // 36 positions per half second
  localparam logic [7:0]  RAMP_RST   = 8'h0F;         // ramp 15
  localparam logic [7:0]  RAMP_MIN   = 8'h01;         // smallest legal ramp
  // ****************************************
  // command sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARG1 = 3'h1,
    ST_ARG2 = 3'h3,
    ST_WAIT = 3'h2,
    ST_SEND = 3'h6
  } wmc_state_type;
endpackage : wmc_pkg
`default_nettype wire

// ===== rtl/wmc_serial_if.sv
`timescale 1ns/100ps
`default_nettype none
// byte stream between the sequencer and the line driver
interface wmc_serial_if;
  logic       rx_valid;  // one-cycle pulse per received byte
  logic [7:0] rx_byte;   // received byte
  logic       tx_valid;  // one-cycle send request
  logic [7:0] tx_byte;   // byte to send
  logic       tx_ready;  // transmitter idle
  modport core (input rx_valid, rx_byte, tx_ready, output tx_valid, tx_byte);
  modport uart (output rx_valid, rx_byte, tx_ready, input tx_valid, tx_byte);
endinterface : wmc_serial_if
`default_nettype wire

// ===== rtl/wmc_uart.sv
`timescale 1ns/100ps
`default_nettype none
module wmc_uart
  import wmc_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   data_in,
  output var  logic   data_out,
  output var  logic   data_oe,
  wmc_serial_if.uart  ser
);
  if (BIT_CYCLES < 4) begin : g_chk
    $error("bit period too short");
  end

  logic [15:0] rx_cnt;   // bit timer, receive
  logic [3:0]  rx_bit;   // receive bit index
  logic [7:0]  rx_sh;    // receive shifter
  logic        rx_busy;  // frame in progress
  logic [15:0] tx_cnt;   // bit timer, transmit
  logic [3:0]  tx_bit;   // transmit bit index
  logic [9:0]  tx_sh;    // stop, data, start
  logic        tx_busy;  // frame in progress
  logic [15:0] oe_len;   // drive length, checked below

  assign ser.rx_byte  = rx_sh;
  assign ser.tx_ready = !tx_busy;

  // ****************************************
  // receiver, lsb first, sampled mid bit
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy      <= 1'b0;
      rx_cnt       <= 16'h0000;
      rx_bit       <= 4'h0;
      rx_sh        <= 8'h00;
      ser.rx_valid <= 1'b0;
    end else begin
      ser.rx_valid <= 1'b0;
      if (!rx_busy) begin
        // own frames are not heard back
        if (!data_in && !tx_busy) begin
          rx_busy <= 1'b1;
          rx_cnt  <= 16'(BIT_CYCLES / 2);
          rx_bit  <= 4'h0;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= 16'(BIT_CYCLES - 1);
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0) begin
          rx_busy <= !data_in;                      // glitch drops the frame
        end else if (rx_bit <= 4'h8) begin
          rx_sh <= {data_in, rx_sh[7:1]};
        end else begin
          rx_busy      <= 1'b0;
          ser.rx_valid <= data_in;                  // bad stop bit discards
        end
      end
    end
  end

  // ****************************************
  // transmitter, drives the line only in a frame
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy  <= 1'b0;
      tx_cnt   <= 16'h0000;
      tx_bit   <= 4'h0;
      tx_sh    <= 10'h3FF;
      data_out <= 1'b1;
      data_oe  <= 1'b0;
    end else if (!tx_busy) begin
      if (ser.tx_valid) begin
        tx_busy  <= 1'b1;
        tx_sh    <= {1'b1, ser.tx_byte, 1'b0};
        tx_cnt   <= 16'(BIT_CYCLES - 1);
        tx_bit   <= 4'h0;
        data_out <= 1'b0;
        data_oe  <= 1'b1;
      end
    end else if (tx_cnt != 16'h0000) begin
      tx_cnt <= tx_cnt - 16'h0001;
    end else if (tx_bit == 4'h9) begin
      tx_busy  <= 1'b0;
      data_out <= 1'b1;
      data_oe  <= 1'b0;
    end else begin
      tx_bit   <= tx_bit + 4'h1;
      tx_cnt   <= 16'(BIT_CYCLES - 1);
      tx_sh    <= {1'b1, tx_sh[9:1]};
      data_out <= tx_sh[1];
    end
  end

  // drive length counter for the frame check
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oe_len <= 16'h0000;
    else        oe_len <= data_oe ? oe_len + 16'h0001 : 16'h0000;
  end

  // ****************************************
  // checks
  // ****************************************
  frame_length_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(data_oe) |-> oe_len == 16'(10 * BIT_CYCLES))
    else $error("reply frame not ten bit times");
  line_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    !tx_busy |-> !data_oe)
    else $error("line driven while idle");
endmodule : wmc_uart
`default_nettype wire
